// *** logic/smes_pkg.sv ***
// package: constants and carrier types for the sync mode entry sequencer
package smes_pkg;
    // ----------------------------------------------------------------
    // timing, counted in crystal clock cycles except RESET_WAIT_INSTR, which counts instruction cycles
    // ----------------------------------------------------------------
    localparam int unsigned SS_TO_TEST_CYC = 4;
    localparam int unsigned TEST_HIGH_MIN_CYC = 4;
    localparam int unsigned FALL_TO_ORIGIN_EDGES = 2;
    localparam int unsigned SS_RETURN_CYC = 4;
    localparam int unsigned INSTR_CYCLE_CLK = 15;
    localparam int unsigned RESET_WAIT_INSTR = 5;
    localparam int unsigned RESET_WAIT_CLK = RESET_WAIT_INSTR * INSTR_CYCLE_CLK;
    localparam int unsigned PRESCALE_DIV = 15;
    localparam int unsigned CNT_W = 8;
    localparam logic [3:0] PRESCALE_RST = 4'h0;
    localparam logic [3:0] TSTATE_FIRST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

    // ----------------------------------------------------------------
    // decoded operating modes
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        SMES_MODE_NORMAL = 7'h01,
        SMES_MODE_SYNC = 7'h02,
        SMES_MODE_PROG = 7'h04,
        SMES_MODE_VERIFY = 7'h08,
        SMES_MODE_SIG_PROG = 7'h10,
        SMES_MODE_SIG_VERIFY = 7'h20,
        SMES_MODE_SEC = 7'h40
    } smes_mode_t;

    // sync entry sequence
    typedef enum logic [5:0] {
        SMES_ST_IDLE = 6'h01,
        SMES_ST_ARMED = 6'h02,
        SMES_ST_HOLD = 6'h04,
        SMES_ST_ALIGN = 6'h08,
        SMES_ST_RUN = 6'h10,
        SMES_ST_FAULT = 6'h20
    } smes_state_t;

    // sampled pin levels
    typedef struct packed {
        logic test_zero_input;
        logic reset_n;
        logic ss_hv;
        logic ss_n;
        logic external_access_pin;
        logic prog;
        logic [7:0] port1;
        logic [2:0] port2;
    } smes_pins_t;

    // timing status toward the core
    typedef struct packed {
        logic [3:0] prescale;
        logic [3:0] tstate;
        logic origin;
        logic core_hold;
    } smes_timing_t;
endpackage : smes_pkg

// *** logic/smes_sync2.sv ***
// two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
`default_nettype none
module smes_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock, reset and enable
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    // data
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } smes_sync_t;

    smes_sync_t r;
    smes_sync_t next_r;

    always_comb begin
        next_r = r;
        if (i_ce) begin
            next_r.meta = i_d;
            next_r.q = r.meta;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_q = r.q;
endmodule : smes_sync2
`default_nettype wire

// *** logic/smes_top.sv ***
// sync mode entry sequencer and access code decoder
`timescale 1ns/10ps
`default_nettype none
module smes_top #(
    parameter int unsigned TEST_MIN = smes_pkg::TEST_HIGH_MIN_CYC,
    parameter int unsigned SS_ARM = smes_pkg::SS_TO_TEST_CYC
) (
    // clock, reset, enable (i_mclk stands for the crystal clock input)
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    // pins
    input wire logic i_test_zero_input,
    input wire logic i_reset_n,
    input wire logic i_ss_hv,
    input wire logic i_ss_n,
    input wire logic i_external_access_pin,
    input wire logic i_prog,
    input wire logic [7:0] i_port1,
    input wire logic [2:0] i_port2,
    // status
    output smes_pkg::smes_mode_t o_mode,
    output smes_pkg::smes_timing_t o_timing,
    output logic o_seq_fault,
    output logic o_run_ok
);
    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    smes_pkg::smes_pins_t raw;
    smes_pkg::smes_pins_t pins;

    assign raw = '{test_zero_input: i_test_zero_input, reset_n: i_reset_n,
                   ss_hv: i_ss_hv, ss_n: i_ss_n,
                   external_access_pin: i_external_access_pin, prog: i_prog,
                   port1: i_port1, port2: i_port2};

    smes_sync2 #(.WIDTH($bits(smes_pkg::smes_pins_t))) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d(raw),
        .o_q(pins)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        smes_pkg::smes_state_t st;
        logic [smes_pkg::CNT_W-1:0] cnt;
        logic [smes_pkg::CNT_W-1:0] ss_cnt;
        logic test_d;
        logic ss_hv_d;
        logic ss_return_seen;
        logic [3:0] prescale;
        logic [3:0] tstate;
        logic origin;
        logic core_hold;
        smes_pkg::smes_mode_t mode;
        logic fault;
        logic run_ok;
    } smes_reg_t;

    smes_reg_t r;
    smes_reg_t next_r;

    // counters read one less than the edges seen since their start event
    localparam logic [smes_pkg::CNT_W-1:0] TEST_MIN_C = smes_pkg::CNT_W'(TEST_MIN - 1);
    localparam logic [smes_pkg::CNT_W-1:0] SS_ARM_C = smes_pkg::CNT_W'(SS_ARM - 1);
    localparam logic [smes_pkg::CNT_W-1:0] ALIGN_C =
        smes_pkg::CNT_W'(smes_pkg::FALL_TO_ORIGIN_EDGES - 1);
    localparam logic [smes_pkg::CNT_W-1:0] RST_WAIT_C =
        smes_pkg::CNT_W'(smes_pkg::RESET_WAIT_CLK - 1);
    localparam logic [3:0] PRE_LAST = 4'(smes_pkg::PRESCALE_DIV - 1);
    localparam logic [3:0] TS_LAST = 4'h4;

    function automatic smes_pkg::smes_mode_t decode(input smes_pkg::smes_pins_t p);
        smes_pkg::smes_mode_t m;
        m = smes_pkg::SMES_MODE_NORMAL;
        if (p.ss_hv && !p.reset_n && !p.external_access_pin) begin
            m = smes_pkg::SMES_MODE_SYNC;
        end else if (p.external_access_pin && p.ss_n) begin
            if (p.port2 == 3'h0 && p.port1[0] == 1'b0 && (&p.port1[4:1])) begin
                // read-out needs test high with the strobe idle
                m = (p.test_zero_input && p.prog) ? smes_pkg::SMES_MODE_SIG_VERIFY
                                                  : smes_pkg::SMES_MODE_SIG_PROG;
            end else if (p.port2 == 3'h0) begin
                m = smes_pkg::SMES_MODE_SEC;
            end else if (p.test_zero_input) begin
                m = smes_pkg::SMES_MODE_VERIFY;
            end else begin
                m = smes_pkg::SMES_MODE_PROG;
            end
        end
        return m;
    endfunction : decode

    always_comb begin
        next_r = r;
        if (i_ce) begin
            next_r.test_d = pins.test_zero_input;
            next_r.ss_hv_d = pins.ss_hv;
            next_r.mode = decode(pins);
            next_r.origin = 1'b0;
            // free-running timing chain outside hold
            if (!r.core_hold) begin
                if (r.prescale == PRE_LAST) begin
                    next_r.prescale = smes_pkg::PRESCALE_RST;
                    next_r.tstate = (r.tstate == TS_LAST) ? smes_pkg::TSTATE_FIRST
                                                          : r.tstate + 4'h1;
                end else begin
                    next_r.prescale = r.prescale + 4'h1;
                end
            end
            if (r.cnt != 8'hFF) begin
                next_r.cnt = r.cnt + 8'h01;
            end
            // leaving high voltage outside the run phase aborts entry
            if (!pins.ss_hv && r.st != smes_pkg::SMES_ST_RUN
                    && r.st != smes_pkg::SMES_ST_IDLE) begin
                next_r.st = smes_pkg::SMES_ST_IDLE;
                next_r.core_hold = 1'b0;
            end else begin
                case (r.st)
                    smes_pkg::SMES_ST_IDLE: begin
                        next_r.run_ok = 1'b0;
                        if (pins.ss_hv && !pins.external_access_pin) begin
                            next_r.st = smes_pkg::SMES_ST_ARMED;
                            next_r.cnt = smes_pkg::CNT_RST;
                            next_r.fault = 1'b0;
                        end
                    end
                    smes_pkg::SMES_ST_ARMED: begin
                        if (pins.test_zero_input && !r.test_d) begin
                            // early rise is flagged but still honoured
                            if (r.cnt < SS_ARM_C) begin
                                next_r.fault = 1'b1;
                            end
                            next_r.st = smes_pkg::SMES_ST_HOLD;
                            next_r.cnt = smes_pkg::CNT_RST;
                            next_r.core_hold = 1'b1;
                        end
                    end
                    smes_pkg::SMES_ST_HOLD: begin
                        next_r.prescale = smes_pkg::PRESCALE_RST;
                        next_r.tstate = smes_pkg::TSTATE_FIRST;
                        if (!pins.test_zero_input) begin
                            if (r.cnt < TEST_MIN_C) begin
                                next_r.fault = 1'b1;
                            end
                            // falling in the low phase is the other party's job
                            next_r.st = smes_pkg::SMES_ST_ALIGN;
                            next_r.cnt = smes_pkg::CNT_RST;
                        end
                    end
                    smes_pkg::SMES_ST_ALIGN: begin
                        next_r.prescale = smes_pkg::PRESCALE_RST;
                        next_r.tstate = smes_pkg::TSTATE_FIRST;
                        if (r.cnt == ALIGN_C) begin
                            next_r.st = smes_pkg::SMES_ST_RUN;
                            next_r.core_hold = 1'b0;
                            next_r.origin = 1'b1;
                            next_r.ss_cnt = smes_pkg::CNT_RST;
                            next_r.ss_return_seen = 1'b0;
                        end
                    end
                    smes_pkg::SMES_ST_RUN: begin
                        if (r.ss_cnt != 8'hFF) begin
                            next_r.ss_cnt = r.ss_cnt + 8'h01;
                        end
                        if (!pins.ss_hv && r.ss_hv_d) begin
                            next_r.ss_return_seen = 1'b1;
                            // wait is timed from the return itself
                            next_r.ss_cnt = smes_pkg::CNT_RST;
                        end
                        if (pins.reset_n) begin
                            // reset too soon after select return
                            if (!r.ss_return_seen || r.ss_cnt < RST_WAIT_C) begin
                                next_r.fault = 1'b1;
                            end
                            next_r.run_ok = 1'b1;
                            next_r.st = smes_pkg::SMES_ST_IDLE;
                        end
                    end
                    default: begin
                        next_r.st = smes_pkg::SMES_ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            r <= '{st: smes_pkg::SMES_ST_IDLE, mode: smes_pkg::SMES_MODE_NORMAL,
                   default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign o_mode = r.mode;
    assign o_timing = '{prescale: r.prescale, tstate: r.tstate,
                        origin: r.origin, core_hold: r.core_hold};
    assign o_seq_fault = r.fault;
    assign o_run_ok = r.run_ok;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_fall_seen;
        r.st == smes_pkg::SMES_ST_HOLD && !pins.test_zero_input && pins.ss_hv && i_ce;
    endsequence

    AST_ORIGIN_AFTER_FALL: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_fall_seen ##1 ((i_ce && pins.ss_hv) [*2]) |=> r.origin)
        else $error("origin not reached two edges after test fall");
    AST_HOLD_CLEARS: assert property (@(posedge i_mclk) disable iff (i_rst)
        (r.st == smes_pkg::SMES_ST_HOLD && pins.ss_hv && i_ce)
        |=> (r.prescale == smes_pkg::PRESCALE_RST && r.tstate == smes_pkg::TSTATE_FIRST))
        else $error("timing chain not held in reset");
    AST_HOLD_ENTRY: assert property (@(posedge i_mclk) disable iff (i_rst)
        (r.st == smes_pkg::SMES_ST_ARMED && pins.test_zero_input && !r.test_d
         && pins.ss_hv && i_ce) |=> r.core_hold)
        else $error("hold missing after test rise");
    AST_HV_ONLY: assert property (@(posedge i_mclk) disable iff (i_rst)
        (r.st == smes_pkg::SMES_ST_HOLD) |-> $past(pins.ss_hv))
        else $error("sync hold without high voltage");
    AST_EARLY_RISE: assert property (@(posedge i_mclk) disable iff (i_rst)
        (r.st == smes_pkg::SMES_ST_ARMED && r.cnt < SS_ARM_C && pins.ss_hv
         && pins.test_zero_input && !r.test_d && i_ce) |=> r.fault)
        else $error("early test rise not flagged");
    AST_SHORT_HIGH: assert property (@(posedge i_mclk) disable iff (i_rst)
        (r.st == smes_pkg::SMES_ST_HOLD && r.cnt < TEST_MIN_C && pins.ss_hv
         && !pins.test_zero_input && i_ce) |=> r.fault)
        else $error("short test high not flagged");
    AST_RESET_WAIT: assert property (@(posedge i_mclk) disable iff (i_rst)
        (r.st == smes_pkg::SMES_ST_RUN && pins.reset_n && !r.ss_return_seen && i_ce)
        |=> (r.fault && r.run_ok))
        else $error("early reset release not flagged");
    AST_SYNC_DECODE: assert property (@(posedge i_mclk) disable iff (i_rst)
        (pins.ss_hv && !pins.reset_n && !pins.external_access_pin && i_ce)
        |=> r.mode == smes_pkg::SMES_MODE_SYNC)
        else $error("sync mode not decoded");
    AST_SS_RETURN: assert property (@(posedge i_mclk) disable iff (i_rst)
        (r.st == smes_pkg::SMES_ST_RUN && !pins.ss_hv && r.ss_hv_d && !pins.reset_n && i_ce)
        |=> r.ss_return_seen)
        else $error("select return not recorded");
endmodule : smes_top
`default_nettype wire

// *** sim/smes_ate_model.sv ***
// behavioural tester that walks the sync entry pin sequence
`timescale 1ns/10ps
`default_nettype none
module smes_ate_model (
    // clock and control
    input wire logic i_mclk,
    input wire logic i_start,
    input wire logic i_short,
    input wire logic [3:0] i_slack,
    // pins toward the device, plus a busy flag
    output logic o_test,
    output logic o_ss_hv,
    output logic o_reset_n,
    output logic o_busy
);
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        o_test = 1'b0;
        o_ss_hv = 1'b0;
        o_reset_n = 1'b0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_mclk);
            if (i_start === 1'b1) begin
                o_busy <= 1'b1;
                o_reset_n <= 1'b0;
                o_ss_hv <= 1'b1;
                repeat (4 + i_slack) @(posedge i_mclk);
                o_test <= 1'b1;
                // short high time only when a scenario asks for a violation
                repeat (i_short ? 2 : 4 + i_slack) @(posedge i_mclk);
                @(negedge i_mclk);
                o_test <= 1'b0;
                repeat (4) @(posedge i_mclk);
                o_ss_hv <= 1'b0;
                // zero slack gives exactly the shortest legal wait
                repeat (smes_pkg::RESET_WAIT_CLK + i_slack) @(posedge i_mclk);
                o_reset_n <= 1'b1;
                @(posedge i_mclk);
                o_busy <= 1'b0;
            end
        end
    end
endmodule : smes_ate_model
`default_nettype wire

// *** sim/tb_smes_top.sv ***
// self-checking bench for the sync mode entry sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_smes_top;
    logic i_mclk, i_rst, test, reset_n, ss_hv, ea, prog, use_ate, start, short_hi, ss_n, ce;
    smes_pkg::smes_mode_t want;
    logic ate_test, ate_ss_hv, ate_reset_n, ate_busy, o_seq_fault, o_run_ok;
    logic [7:0] port1;
    logic [2:0] port2;
    logic [3:0] slack;
    logic [31:0] r;
    smes_pkg::smes_mode_t o_mode;
    smes_pkg::smes_timing_t o_timing;
    int err_total, samples_checked, seed, cycles, k;

    smes_ate_model smes_ate_model_inst (.i_mclk(i_mclk), .i_start(start), .i_short(short_hi),
        .i_slack(slack), .o_test(ate_test), .o_ss_hv(ate_ss_hv), .o_reset_n(ate_reset_n),
        .o_busy(ate_busy));
    smes_top smes_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce),
        .i_test_zero_input(use_ate ? ate_test : test), .i_reset_n(use_ate ? ate_reset_n : reset_n),
        .i_ss_hv(use_ate ? ate_ss_hv : ss_hv), .i_ss_n(ss_n), .i_external_access_pin(ea),
        .i_prog(prog), .i_port1(port1), .i_port2(port2), .o_mode(o_mode), .o_timing(o_timing),
        .o_seq_fault(o_seq_fault), .o_run_ok(o_run_ok));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check_value(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check_value

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    function automatic smes_pkg::smes_mode_t exp_mode(input logic t, input logic rn,
        input logic hv, input logic sn, input logic e, input logic pg, input logic [7:0] p1,
        input logic [2:0] p2);
        if (hv && !rn && !e) return smes_pkg::SMES_MODE_SYNC;
        if (!e || !sn) return smes_pkg::SMES_MODE_NORMAL;
        if (p2 == 3'h0 && p1[4:0] == 5'h1E)
            return (t && pg) ? smes_pkg::SMES_MODE_SIG_VERIFY : smes_pkg::SMES_MODE_SIG_PROG;
        if (p2 == 3'h0) return smes_pkg::SMES_MODE_SEC;
        return t ? smes_pkg::SMES_MODE_VERIFY : smes_pkg::SMES_MODE_PROG;
    endfunction : exp_mode

    task automatic run_seq(input logic sh, input logic [3:0] sl);
        int n;
        int org;
        logic ok;
        org = 0;
        ok = 1'b0;
        @(posedge i_mclk);
        ea <= 1'b0;
        use_ate <= 1'b1;
        short_hi <= sh;
        slack <= sl;
        start <= 1'b1;
        @(posedge i_mclk);
        start <= 1'b0;
        @(negedge ate_test);
        #1;
        check_value(16'(o_mode), 16'(smes_pkg::SMES_MODE_SYNC));
        for (n = 1; n <= 150; n++) begin
            @(posedge i_mclk);
            #1;
            // the synchronised fall has not reached the sequencer yet
            if (n == 2) check_value(16'(o_timing.core_hold), 16'h0001);
            if (o_timing.origin === 1'b1 && org == 0) begin
                org = n;
                check_value(16'(o_timing.prescale), 16'(smes_pkg::PRESCALE_RST));
                check_value(16'(o_timing.tstate), 16'(smes_pkg::TSTATE_FIRST));
            end
            if (o_run_ok === 1'b1) ok = 1'b1;
        end
        // fault stays until the next arming, so it is read after the walk
        check_value(16'(o_seq_fault), 16'(sh));
        if (!sh) begin
            check_value(16'(org), 16'h0005);
            check_value(16'(ok), 16'h0001);
        end
    endtask : run_seq

    // ----------------------------------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        {test, reset_n, ss_hv, ea, prog, use_ate, start, short_hi} = 8'h00;
        {ss_n, ce} = 2'h3;
        port1 = 8'h00;
        port2 = 3'h0;
        slack = 4'h0;
        seed = 90;
        i_rst = 1'b1;
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        // random pin levels, access code patterns biased in
        for (k = 0; k < 60; k++) begin
            @(posedge i_mclk);
            r = $random(seed);
            port1 <= r[8] ? {r[7:5], 5'h1E} : r[7:0];
            port2 <= r[9] ? 3'h0 : r[12:10];
            {test, reset_n, ss_hv, ea, prog} <= r[17:13];
            ss_n <= r[18];
            repeat (4) @(posedge i_mclk);
            #1;
            want = exp_mode(test, reset_n, ss_hv, ss_n, ea, prog, port1, port2);
            check_value(16'(o_mode), 16'(want));
        end
        // mid-run reset returns outputs to their idle values
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        check_value(16'(o_mode), 16'(smes_pkg::SMES_MODE_NORMAL));
        check_value(16'({o_timing, o_seq_fault, o_run_ok}), 16'h0000);
        @(posedge i_mclk);
        i_rst <= 1'b0;
        // corner: test rises two cycles after high voltage
        @(posedge i_mclk);
        {test, reset_n, ss_hv, ea} <= 4'h2;
        repeat (2) @(posedge i_mclk);
        test <= 1'b1;
        repeat (4) @(posedge i_mclk);
        #1;
        check_value(16'(o_seq_fault), 16'h0001);
        check_value(16'(o_mode), 16'(smes_pkg::SMES_MODE_SYNC));
        // enable low: pin changes must not reach the decode
        @(posedge i_mclk);
        {ce, test, ea} <= 3'h1;
        repeat (4) @(posedge i_mclk);
        #1;
        check_value(16'(o_mode), 16'(smes_pkg::SMES_MODE_SYNC));
        @(posedge i_mclk);
        ce <= 1'b1;
        repeat (4) @(posedge i_mclk);
        #1;
        want = exp_mode(test, reset_n, ss_hv, ss_n, ea, prog, port1, port2);
        check_value(16'(o_mode), 16'(want));
        // reset released with no select return seen still ends the run
        @(posedge i_mclk);
        {reset_n, ss_hv} <= 2'h2;
        repeat (3) @(posedge i_mclk);
        #1;
        check_value(16'(o_run_ok), 16'h0001);
        run_seq(1'b1, 4'h0);
        run_seq(1'b0, 4'h0);
        for (k = 0; k < 3; k++) run_seq(1'b0, 4'($random(seed)));
        finish_test();
    end
endmodule : tb_smes_top
`default_nettype wire
